/* design/gp_bank.sv */
// Purpose: five general-purpose pin ports behind a classic wishbone slave
// Assumes: 25 MHz clk, async active-high rst, pins asynchronous to clk
// Notes:   every access answers one cycle after it is taken
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "gp_consts.svh"

module gp_bank (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // interrupt
   output var  logic        irq,
   // port zero
   input  wire logic [7:0]  port_zero_pins_in,
   output var  logic [7:0]  port_zero_pins_out,
   output var  logic [7:0]  port_zero_pins_oe,
   output var  logic [7:0]  port_zero_pins_pu,
   // port one
   input  wire logic [7:0]  port_one_pins_in,
   output var  logic [7:0]  port_one_pins_out,
   output var  logic [7:0]  port_one_pins_oe,
   output var  logic [7:0]  port_one_pins_pu,
   // port two
   input  wire logic [7:0]  port_two_pins_in,
   output var  logic [7:0]  port_two_pins_out,
   output var  logic [7:0]  port_two_pins_oe,
   output var  logic [7:0]  port_two_pins_pu,
   // port three
   input  wire logic [4:0]  port_three_pins_in,
   output var  logic [4:0]  port_three_pins_out,
   output var  logic [4:0]  port_three_pins_oe,
   output var  logic [4:0]  port_three_pins_pu,
   // port four
   input  wire logic [7:0]  port_four_pins_in,
   output var  logic [7:0]  port_four_pins_out,
   output var  logic [7:0]  port_four_pins_oe,
   output var  logic [7:0]  port_four_pins_pu
);

   ////////////////////////////////////////////////////////////////////////
   // per-port arrays
   gp_pkg::gp_byte_type data    [5];
   gp_pkg::gp_byte_type dir     [5];
   gp_pkg::gp_byte_type odrain  [5];
   gp_pkg::gp_byte_type pull_en [5];
   gp_pkg::gp_byte_type dir_eff [5];
   gp_pkg::gp_byte_type pin_in  [5];
   gp_pkg::gp_byte_type pin_out [5];
   gp_pkg::gp_byte_type pin_oe  [5];
   gp_pkg::gp_byte_type pin_pu  [5];
   gp_pkg::gp_byte_type level   [5];
   gp_pkg::gp_byte_type change  [5];
   gp_pkg::gp_byte_type impl    [5];
   gp_pkg::gp_byte_type fixed   [5];

   // bus decode
   logic        take;
   logic        wr;
   logic [2:0]  blk;
   logic [2:0]  regsel;
   logic        irq_blk;
   logic [31:0] next_dat;

   // interrupt side
   gp_pkg::gp_irq_type events;
   gp_pkg::gp_irq_type status;
   gp_pkg::gp_irq_type mask;
   logic        status_rd;
   logic        mask_wr;

   ////////////////////////////////////////////////////////////////////////
   // request taken once; ack follows at the next edge, then drops
   assign take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr      = take & wb_we_i;
   assign blk     = wb_adr_i[`GP_ADR_PORT_HI:`GP_ADR_PORT_LO];
   assign regsel  = wb_adr_i[`GP_ADR_REG_HI:`GP_ADR_REG_LO];
   assign irq_blk = (blk == `GP_IRQ_BLOCK);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= take;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin groups packed into the common eight-bit shape
   assign pin_in[0] = port_zero_pins_in;
   assign pin_in[1] = port_one_pins_in;
   assign pin_in[2] = port_two_pins_in;
   assign pin_in[3] = {3'h0, port_three_pins_in};
   assign pin_in[4] = port_four_pins_in;

   // per-port register set, pin logic and fixed features
   for (genvar p = 0; p < 5; p++) begin : g_port
      // port three lacks its top bits; port one bit five has no input
      assign impl[p]  = (p == 3) ? `GP_IMPL_PORT3 : `GP_IMPL_FULL;
      assign fixed[p] = (p == 1) ? `GP_FIXED_OUT_P1 : `GP_RST_BYTE;
      // fixed output bit reads as output and drives unless open-drain with data high; reset data keeps it low
      assign dir_eff[p] = (dir[p] | fixed[p]) & impl[p];

      // writes land at the acking edge; lane 0 carries the byte
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            data[p]   <= `GP_RST_BYTE;
            dir[p]    <= `GP_RST_BYTE;
            odrain[p] <= `GP_RST_BYTE;
            pull_en[p] <= `GP_RST_BYTE;
         end else if (wr && wb_sel_i[0] && blk == 3'(p)) begin
            // masked writes so absent bits stay zero
            if (regsel == `GP_REG_DATA) begin
               data[p] <= wb_dat_i[7:0] & impl[p];
            end
            if (regsel == `GP_REG_DIR) begin
               dir[p] <= wb_dat_i[7:0] & impl[p];
            end
            if (regsel == `GP_REG_ODRAIN) begin
               odrain[p] <= wb_dat_i[7:0] & impl[p];
            end
            if (regsel == `GP_REG_PULLUP) begin
               pull_en[p] <= wb_dat_i[7:0] & impl[p];
            end
         end
      end

      gp_pin_bank u_pins (
         .clk     (clk),
         .rst     (rst),
         .data    (data[p]),
         .dir     (dir_eff[p]),
         .odrain  (odrain[p]),
         .pull_en (pull_en[p]),
         .impl    (impl[p] & ~fixed[p]),
         .pin_in  (pin_in[p]),
         .pin_out (pin_out[p]),
         .pin_oe  (pin_oe[p]),
         .pin_pu  (pin_pu[p]),
         .level   (level[p]),
         .change  (change[p])
      );
   end

   // fixed output bit needs drive even though its input side is cut
   // so it is driven here from the same registers, straight off flops
   logic fixed_out;
   logic fixed_oe;
   logic fixed_pu;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fixed_out <= 1'b0;
         fixed_oe  <= 1'b0;
         fixed_pu  <= 1'b0;
      end else begin
         fixed_out <= data[1][5] & ~odrain[1][5];
         fixed_oe  <= ~odrain[1][5] | ~data[1][5];
         fixed_pu  <= pull_en[1][5];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins out
   assign port_zero_pins_out  = pin_out[0];
   assign port_zero_pins_oe   = pin_oe[0];
   assign port_zero_pins_pu   = pin_pu[0];
   assign port_one_pins_out   = {pin_out[1][7:6], fixed_out, pin_out[1][4:0]};
   assign port_one_pins_oe    = {pin_oe[1][7:6], fixed_oe, pin_oe[1][4:0]};
   assign port_one_pins_pu    = {pin_pu[1][7:6], fixed_pu, pin_pu[1][4:0]};
   assign port_two_pins_out   = pin_out[2];
   assign port_two_pins_oe    = pin_oe[2];
   assign port_two_pins_pu    = pin_pu[2];
   assign port_three_pins_out = pin_out[3][4:0];
   assign port_three_pins_oe  = pin_oe[3][4:0];
   assign port_three_pins_pu  = pin_pu[3][4:0];
   assign port_four_pins_out  = pin_out[4];
   assign port_four_pins_oe   = pin_oe[4];
   assign port_four_pins_pu   = pin_pu[4];

   ////////////////////////////////////////////////////////////////////////
   // events only from ports zero, one and four; two and three have none
   assign events = {change[4], change[1], change[0]};

   assign status_rd = take & ~wb_we_i & irq_blk & (regsel == `GP_REG_STATUS);
   assign mask_wr   = wr & irq_blk & (regsel == `GP_REG_MASK);

   gp_irq_ctrl u_irq (
      .clk        (clk),
      .rst        (rst),
      .events     (events),
      .status_rd  (status_rd),
      .mask_wr    (mask_wr),
      .mask_lanes (wb_sel_i[2:0]),
      .mask_wdata (wb_dat_i[23:0]),
      .status     (status),
      .mask       (mask),
      .irq        (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses answer zero rather than hang the bus
   always_comb begin
      next_dat = `GP_RST_WORD;
      if (irq_blk) begin
         if (regsel == `GP_REG_STATUS) begin
            next_dat = {8'h00, status};
         end else if (regsel == `GP_REG_MASK) begin
            next_dat = {8'h00, mask};
         end
      end else begin
         for (int p = 0; p < 5; p++) begin
            if (blk == 3'(p)) begin
               if (regsel == `GP_REG_DATA) begin
                  next_dat = {24'h000000, data[p]};
               end else if (regsel == `GP_REG_DIR) begin
                  next_dat = {24'h000000, dir_eff[p]};
               end else if (regsel == `GP_REG_ODRAIN) begin
                  next_dat = {24'h000000, odrain[p]};
               end else if (regsel == `GP_REG_PULLUP) begin
                  next_dat = {24'h000000, pull_en[p]};
               end else if (regsel == `GP_REG_INPUT) begin
                  next_dat = {24'h000000, level[p]};
               end
            end
         end
      end
   end

   // data is registered with ack so it stands for the ack cycle only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= `GP_RST_WORD;
      end else if (take) begin
         wb_dat_o <= next_dat;
      end else begin
         wb_dat_o <= `GP_RST_WORD;
      end
   end

endmodule
`default_nettype wire

/* design/gp_consts.svh */
// Purpose: offsets, field positions and reset values of the gpio bank
// Assumes: 32-bit classic wishbone, byte addresses, one word per register
// Notes:   port index sits in address bits 7:5, register in bits 4:2
`ifndef GP_CONSTS_SVH
`define GP_CONSTS_SVH

// address fields
`define GP_ADR_PORT_HI    7
`define GP_ADR_PORT_LO    5
`define GP_ADR_REG_HI     4
`define GP_ADR_REG_LO     2

// port block index of the interrupt registers
`define GP_IRQ_BLOCK      3'h5

// register index inside a port block
`define GP_REG_DATA       3'h0
`define GP_REG_DIR        3'h1
`define GP_REG_ODRAIN     3'h2
`define GP_REG_PULLUP     3'h3
`define GP_REG_INPUT      3'h4

// register index inside the interrupt block
`define GP_REG_STATUS     3'h0
`define GP_REG_MASK       3'h1

// implemented bits per port
`define GP_IMPL_FULL      8'hff
`define GP_IMPL_PORT3     8'h1f

// port one fixed output bit
`define GP_FIXED_OUT_P1   8'h20

// reset values
`define GP_RST_BYTE       8'h00
`define GP_RST_IRQ        24'h000000
`define GP_RST_WORD       32'h00000000

// status and mask layout: port 0 low byte, port 1 next, port 4 top
`define GP_IRQ_P0_LO      0
`define GP_IRQ_P1_LO      8
`define GP_IRQ_P4_LO      16

`endif

/* design/gp_irq_ctrl.sv */
// Purpose: sticky interrupt status, mask and the one interrupt line
// Assumes: events are one-cycle pulses on clk
// Notes:   a read of status clears it; a new event in that cycle survives
`timescale 1ns/1ps
`default_nettype none
`include "gp_consts.svh"

module gp_irq_ctrl (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // events and software access
   input  wire gp_pkg::gp_irq_type events,
   input  wire logic            status_rd,
   input  wire logic            mask_wr,
   input  wire logic [2:0]      mask_lanes,
   input  wire gp_pkg::gp_irq_type mask_wdata,
   // state
   output var  gp_pkg::gp_irq_type status,
   output var  gp_pkg::gp_irq_type mask,
   output var  logic            irq
);

   gp_pkg::gp_irq_type next_status;
   gp_pkg::gp_irq_type next_mask;

   // set wins over the read clear so no event is lost
   always_comb begin
      next_status = status_rd ? events : (status | events);
   end

   // byte lanes of the mask
   always_comb begin
      next_mask = mask;
      for (int i = 0; i < 3; i++) begin
         if (mask_wr && mask_lanes[i]) begin
            next_mask[i*8 +: 8] = mask_wdata[i*8 +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= `GP_RST_IRQ;
         mask   <= `GP_RST_IRQ;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         mask   <= next_mask;
         irq    <= |(next_status & next_mask);
      end
   end

endmodule
`default_nettype wire

/* design/gp_pin_bank.sv */
// Purpose: one 8-bit pin group: input sync, output drive, change events
// Assumes: pins are asynchronous to clk
// Notes:   outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "gp_consts.svh"

module gp_pin_bank (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // settings from registers
   input  wire gp_pkg::gp_byte_type data,
   input  wire gp_pkg::gp_byte_type dir,
   input  wire gp_pkg::gp_byte_type odrain,
   input  wire gp_pkg::gp_byte_type pull_en,
   input  wire gp_pkg::gp_byte_type impl,
   // pins
   input  wire gp_pkg::gp_byte_type pin_in,
   output var  gp_pkg::gp_byte_type pin_out,
   output var  gp_pkg::gp_byte_type pin_oe,
   output var  gp_pkg::gp_byte_type pin_pu,
   // state back to the bus side
   output var  gp_pkg::gp_byte_type level,
   output var  gp_pkg::gp_byte_type change
);

   gp_pkg::gp_byte_type meta;
   gp_pkg::gp_byte_type prev;

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser; meta feeds level only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta  <= `GP_RST_BYTE;
         level <= `GP_RST_BYTE;
      end else begin
         meta  <= pin_in;
         level <= meta & impl;
      end
   end

   // change on a pin set as input only; output pins raise no event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev   <= `GP_RST_BYTE;
         change <= `GP_RST_BYTE;
      end else begin
         prev   <= level;
         change <= (prev ^ level) & ~dir & impl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-pin drive: push-pull drives both levels, open-drain only low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out <= `GP_RST_BYTE;
         pin_oe  <= `GP_RST_BYTE;
         pin_pu  <= `GP_RST_BYTE;
      end else begin
         pin_out <= data & ~odrain & impl;
         pin_oe  <= dir & (~odrain | ~data) & impl;
         pin_pu  <= pull_en & impl;
      end
   end

endmodule
`default_nettype wire

/* design/gp_pkg.sv */
// Purpose: shared types of the gpio bank
// Assumes: constants live in gp_consts.svh
// Notes:   none
package gp_pkg;
   typedef logic [7:0]  gp_byte_type;
   typedef logic [23:0] gp_irq_type;
endpackage

/* tb/gp_bank_asserts.sv */
// Purpose: concurrent checks on the gpio bank ports
// Assumes: classic wishbone, one-cycle answer, async active-high rst
// Notes:   port one data register sits at byte address 8'h20
`timescale 1ns/1ps
`default_nettype none

module gp_bank_asserts (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   // interrupt and pins
   input  wire logic        irq,
   input  wire logic [7:0]  port_zero_pins_out,
   input  wire logic [7:0]  port_zero_pins_oe,
   input  wire logic [7:0]  port_zero_pins_pu,
   input  wire logic [7:0]  port_one_pins_out,
   input  wire logic [7:0]  port_one_pins_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic seen_p1_wr;
   //////////////////////////////////////////////////////////////////////
   // request taken, and a request seen one or two cycles back
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_req_seen;
      $past(wb_cyc_i && wb_stb_i) || $past(wb_cyc_i && wb_stb_i, 2);
   endsequence
   // remembers a port one data write; until then bit five stays low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_p1_wr <= 1'b0;
      end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h20) begin
         seen_p1_wr <= 1'b1;
      end
   end
   //////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (s_take |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_stray: assert property (
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_pins_by_write: assert property (
      $changed({port_zero_pins_out, port_zero_pins_oe, port_zero_pins_pu})
      |-> $past(wb_ack_o && wb_we_i))
      else $error("pin drive changed without write");
   a_three_upper_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i[7:5] == 3'h3
      |-> wb_dat_o[31:5] == 27'h0)
      else $error("absent port three bits read nonzero");
   a_unmapped_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i[7:5] > 3'h5 |-> wb_dat_o == 32'h0)
      else $error("unmapped read nonzero");
   a_fixed_bit_drives: assert property (
      !$past(rst) |-> port_one_pins_oe[5])
      else $error("output only bit not driven");
   a_fixed_bit_low: assert property (
      !seen_p1_wr |-> !port_one_pins_out[5])
      else $error("output only bit not low after reset");
   a_irq_drop_cause: assert property ($fell(irq) |-> s_req_seen)
      else $error("interrupt fell without access");
endmodule

bind gp_bank gp_bank_asserts i_chk (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq(irq), .port_zero_pins_out(port_zero_pins_out),
   .port_zero_pins_oe(port_zero_pins_oe),
   .port_zero_pins_pu(port_zero_pins_pu),
   .port_one_pins_out(port_one_pins_out),
   .port_one_pins_oe(port_one_pins_oe));
`default_nettype wire

/* tb/gp_board_model.sv */
// Purpose: board side of one pin group
// Assumes: the board drives every pin the device leaves undriven
// Notes:   no contention model; a driving device simply wins
`timescale 1ns/1ps
`default_nettype none

module gp_board_model (
   // device side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // board side
   input  wire logic [7:0] ext,
   output var  logic [7:0] pin_in
);
   // wire level: device value where driven, board value elsewhere
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   end
endmodule
`default_nettype wire

/* tb/tb_gp_bank.sv */
// Purpose: register and pin level test of the gpio bank
// Assumes: port p at p*8'h20, status at 8'ha0, mask at 8'ha4
// Notes:   pin bit four is toggled on every port; only ports zero, one and four raise events from it
`timescale 1ns/1ps
`default_nettype none

module tb_gp_bank;
   logic             clk;
   logic             rst;
   logic             cyc;
   logic             stb;
   logic             we;
   logic [7:0]       adr;
   logic [31:0]      wdat;
   logic [3:0]       sel;
   wire logic [31:0] rdat;
   wire logic        ack;
   wire logic        irq;
   wire logic [7:0]  p_out [5];
   wire logic [7:0]  p_oe  [5];
   wire logic [7:0]  p_pu  [5];
   wire logic [7:0]  p_in  [5];
   logic [7:0]       ext   [5];
   int               err_count;
   int               cmp_count;
   //////////////////////////////////////////////////////////////////////
   gp_bank i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
      .port_zero_pins_in(p_in[0]), .port_zero_pins_out(p_out[0]),
      .port_zero_pins_oe(p_oe[0]), .port_zero_pins_pu(p_pu[0]),
      .port_one_pins_in(p_in[1]), .port_one_pins_out(p_out[1]),
      .port_one_pins_oe(p_oe[1]), .port_one_pins_pu(p_pu[1]),
      .port_two_pins_in(p_in[2]), .port_two_pins_out(p_out[2]),
      .port_two_pins_oe(p_oe[2]), .port_two_pins_pu(p_pu[2]),
      .port_three_pins_in(p_in[3][4:0]),
      .port_three_pins_out(p_out[3][4:0]),
      .port_three_pins_oe(p_oe[3][4:0]),
      .port_three_pins_pu(p_pu[3][4:0]),
      .port_four_pins_in(p_in[4]), .port_four_pins_out(p_out[4]),
      .port_four_pins_oe(p_oe[4]), .port_four_pins_pu(p_pu[4]));
   // one board model per port; port three uses its low five bits
   for (genvar g = 0; g < 5; g++) begin : g_brd
      gp_board_model i_brd (.pin_out(p_out[g]), .pin_oe(p_oe[g]),
         .ext(ext[g]), .pin_in(p_in[g]));
   end
   // 25 mhz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   //////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ad(input int p, input int r);
      return {p[2:0], r[2:0], 2'b00};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h7;
      adr <= a;
      wdat <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      if (n == 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   // lets a register write reach the pins and the interrupt line
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      int          p;
      int          r;
      logic [7:0]  m;
      logic [7:0]  x;
      logic [7:0]  o;
      logic [7:0]  oe;
      logic [31:0] s;
      logic [31:0] q;
      logic        hit;
      err_count = 0;
      cmp_count = 0;
      {cyc, stb, we, sel, adr, wdat} = '0;
      for (p = 0; p < 5; p++) ext[p] = 8'h00;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // reset state of every port register and pin
      for (p = 0; p < 5; p++) begin
         m = (p == 3) ? 8'h1f : 8'hff;
         x = (p == 1) ? 8'h20 : 8'h00;
         for (r = 0; r < 5; r++) begin
            rd("reset reg", ad(p, r), (r == 1) ? {24'h0, x} : 32'h0);
         end
         chk("reset oe", {24'h0, x}, {24'h0, p_oe[p] & m});
         chk("reset out", 32'h0, {24'h0, p_out[p] & m});
         chk("reset pu", 32'h0, {24'h0, p_pu[p] & m});
      end
      rd("unmapped", 8'hc0, 32'h0);
      rd("mask rst", 8'ha4, 32'h0);
      // mixed direction, drive type and pull-up on each port
      for (p = 0; p < 5; p++) begin
         m = (p == 3) ? 8'h1f : 8'hff;
         x = (p == 1) ? 8'h20 : 8'h00;
         // push-pull pins show data even while the pin is not driven
         o = 8'h95 & ~8'h03 & m;
         oe = ((8'h0f & ~(8'h03 & 8'h95)) | x) & m;
         wr(ad(p, 1), 32'h0f);
         wr(ad(p, 2), 32'h03);
         wr(ad(p, 3), 32'hc6);
         wr(ad(p, 0), 32'h95);
         rd("data", ad(p, 0), {24'h0, 8'h95 & m});
         rd("dir", ad(p, 1), {24'h0, (8'h0f | x) & m});
         rd("pullup", ad(p, 3), {24'h0, 8'hc6 & m});
         settle();
         chk("pin out", {24'h0, o}, {24'h0, p_out[p] & m});
         chk("pin oe", {24'h0, oe}, {24'h0, p_oe[p] & m});
         chk("pin pu", {24'h0, 8'hc6 & m}, {24'h0, p_pu[p] & m});
         rd("input", ad(p, 4), {24'h0, o & oe & ~x});
      end
      bus(1'b0, 8'ha0, 32'h0, q);
      // pin events: enabled, then masked, per port
      for (p = 0; p < 5; p++) begin
         hit = (p == 0 || p == 1 || p == 4);
         s = hit ? 32'h1 << (4 + 8 * ((p == 4) ? 2 : p)) : 32'h0;
         wr(8'ha4, hit ? s : 32'hffffff);
         rd("mask", 8'ha4, hit ? s : 32'hffffff);
         @(posedge clk);
         ext[p] <= 8'h10;
         repeat (8) @(posedge clk);
         #1 chk("irq set", {31'h0, hit}, {31'h0, irq});
         rd("status", 8'ha0, s);
         settle();
         chk("irq clear", 32'h0, {31'h0, irq});
         wr(8'ha4, ~s & 32'hffffff);
         @(posedge clk);
         ext[p] <= 8'h00;
         repeat (8) @(posedge clk);
         #1 chk("irq masked", 32'h0, {31'h0, irq});
         rd("sticky", 8'ha0, s);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
